// ---- hw/phy_tx_pkg.sv ----
// Constants, register map and code tables for the 100 Mb/s transmit path and link indicators.
// ============================================================================
package phy_tx_pkg;

  // ==========================================================================
  // Register map
  localparam logic [11:0] BMC_ADDR = 12'h000;
  localparam logic [11:0] TX_CONFIG_ADDR = 12'h004;
  localparam logic [11:0] RX_CONFIG_ADDR = 12'h008;
  localparam logic [11:0] CFG_ADDR = 12'h00c;
  localparam logic [11:0] PHY_STATUS_ADDR = 12'h0c0;
  localparam int BMC_LOOP_BIT = 14;
  localparam int BMC_SPEED_BIT = 13;
  localparam int BMC_DUPLEX_BIT = 8;
  localparam int TX_CONFIG_CSI_BIT = 31;
  localparam int TX_CONFIG_HEARTBEAT_BIT = 30;
  localparam int TX_CONFIG_MACLOOP_BIT = 29;
  localparam int RX_CONFIG_OWN_TX_BIT = 28;
  localparam int CFG_ENC_BYP_BIT = 0;
  localparam int CFG_SCR_BYP_BIT = 1;
  localparam int CFG_NEG_SEL_LSB = 13;
  localparam int STS_SPEED10_BIT = 1;
  localparam int STS_DUPLEX_BIT = 2;
  localparam int STS_LOOP_BIT = 3;
  localparam int STS_LINK_BIT = 0;
  localparam logic [31:0] BMC_RESET = 32'h0000_2000;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // ==========================================================================
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int FAST_LINK_US = 500;
  localparam int FAST_LINK_CYCLES = FAST_LINK_US * CLK_MHZ;
  localparam int LINK_LOSS_MS = 50;
  localparam int LINK_LOSS_CYCLES = LINK_LOSS_MS * 1000 * CLK_MHZ;
  localparam logic [2:0] NLP_NEEDED = 3'h7;
  localparam logic [2:0] SYM_LAST = 3'h4;

  // ==========================================================================
  // Code-groups
  localparam logic [4:0] CG_IDLE = 5'h1f;
  localparam logic [4:0] CG_HALT = 5'h04;
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0d;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [10:0] SCR_SEED = 11'h7ff;

  typedef enum logic [2:0] {
    ENC_IDLE = 3'b000,
    ENC_J = 3'b001,
    ENC_K = 3'b010,
    ENC_DATA = 3'b011,
    ENC_T = 3'b100,
    ENC_R = 3'b101
  } enc_state_t;

  function automatic logic [4:0] nibble_to_cg(input logic [3:0] n);
    logic [4:0] cg;
    cg = CG_HALT;
    unique case (n)
      4'h0: cg = 5'h1e;
      4'h1: cg = 5'h09;
      4'h2: cg = 5'h14;
      4'h3: cg = 5'h15;
      4'h4: cg = 5'h0a;
      4'h5: cg = 5'h0b;
      4'h6: cg = 5'h0e;
      4'h7: cg = 5'h0f;
      4'h8: cg = 5'h12;
      4'h9: cg = 5'h13;
      4'ha: cg = 5'h16;
      4'hb: cg = 5'h17;
      4'hc: cg = 5'h1a;
      4'hd: cg = 5'h1b;
      4'he: cg = 5'h1c;
      4'hf: cg = 5'h1d;
    endcase
    return cg;
  endfunction : nibble_to_cg

endpackage : phy_tx_pkg

// ---- hw/tx_bit_if.sv ----
// Serial NRZ bit stream from the code-group encoder to the line coder.
`timescale 1ns/1ns
`default_nettype none
interface tx_bit_if;
  logic nrz_bit;
  logic scr_bypass;
  logic tx_active;
  modport src (output nrz_bit, output tx_active, input scr_bypass);
  modport dst (input nrz_bit, input tx_active, output scr_bypass);
endinterface : tx_bit_if
`default_nettype wire

// ---- hw/cg_encoder.sv ----
// Code-group encoder with delimiter and idle injection and a five-bit serialiser.
`timescale 1ns/1ns
`default_nettype none
module cg_encoder (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  input wire logic [4:0] raw_sym,
  input wire logic enc_bypass,
  output logic nibble_take,
  tx_bit_if.src bits
);
  import phy_tx_pkg::*;

  enc_state_t state_reg, state_next;
  logic [2:0] cnt_reg;
  logic [4:0] shift_reg, sym_next;
  logic boundary;

  assign boundary = (cnt_reg == SYM_LAST);
  assign nibble_take = boundary && (enc_bypass || tx_en);

  // ==========================================================================
  // Framing state and next symbol.
  always_comb begin
    state_next = state_reg;
    sym_next = CG_IDLE;
    if (enc_bypass) begin
      state_next = ENC_IDLE;
      sym_next = raw_sym;
    end else begin
      unique case (state_reg)
        ENC_IDLE: if (tx_en) begin
          state_next = ENC_J;
          sym_next = CG_J;
        end
        ENC_J: begin
          state_next = ENC_K;
          sym_next = CG_K;
        end
        ENC_K, ENC_DATA: if (tx_en) begin
          state_next = ENC_DATA;
          sym_next = nibble_to_cg(txd);
        end else begin
          state_next = ENC_T;
          sym_next = CG_T;
        end
        ENC_T: begin
          state_next = ENC_R;
          sym_next = CG_R;
        end
        ENC_R: state_next = ENC_IDLE;
        default: state_next = ENC_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= 3'h0;
    end else begin
      cnt_reg <= boundary ? 3'h0 : cnt_reg + 3'h1;
    end
  end

  // Symbols shift out MSB first, one bit per clock.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ENC_IDLE;
      shift_reg <= CG_IDLE;
    end else if (boundary) begin
      state_reg <= state_next;
      shift_reg <= sym_next;
    end else begin
      shift_reg <= {shift_reg[3:0], 1'b0};
    end
  end

  assign bits.nrz_bit = shift_reg[4];
  assign bits.tx_active = (state_reg != ENC_IDLE) || enc_bypass;

  // ==========================================================================
  // Checks.
  sequence data_ends_s;
    boundary && !enc_bypass && !tx_en && (state_reg == ENC_DATA);
  endsequence

  sequence start_s;
    boundary && !enc_bypass && tx_en && (state_reg == ENC_IDLE);
  endsequence

  end_delim_a: assert property (@(posedge pclk) disable iff (!presetn)
    data_ends_s |=> (shift_reg == CG_T) ##5 (shift_reg == CG_R) ##5 (shift_reg == CG_IDLE || enc_bypass))
    else $error("end delimiter pair not sent");

  start_delim_a: assert property (@(posedge pclk) disable iff (!presetn)
    start_s |=> (shift_reg == CG_J) ##5 (shift_reg == CG_K || enc_bypass))
    else $error("start delimiter pair not sent");

  idle_fill_a: assert property (@(posedge pclk) disable iff (!presetn)
    (boundary && !enc_bypass && !tx_en && state_reg == ENC_IDLE) |=> (shift_reg == CG_IDLE))
    else $error("idle not sent between frames");

endmodule : cg_encoder
`default_nettype wire

// ---- hw/line_coder.sv ----
// Scrambler, NRZI encoder and MLT-3 splitter for the serial transmit stream.
`timescale 1ns/1ns
`default_nettype none
module line_coder (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic scr_bypass,
  output logic nrzi_out,
  output logic mlt_pos,
  output logic mlt_neg,
  tx_bit_if.dst bits
);
  import phy_tx_pkg::*;

  logic [10:0] lfsr_reg;
  logic scr_bit;
  logic nrzi_reg, phase_reg, pos_reg, neg_reg;

  assign bits.scr_bypass = scr_bypass;
  // The LFSR runs every clock even when bypassed, so leaving bypass gives a live sequence.
  assign scr_bit = bits.nrz_bit ^ (bits.scr_bypass ? 1'b0 : lfsr_reg[10]);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_reg <= SCR_SEED;
    end else begin
      lfsr_reg <= {lfsr_reg[9:0], lfsr_reg[10] ^ lfsr_reg[8]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nrzi_reg <= 1'b0;
    end else begin
      nrzi_reg <= nrzi_reg ^ scr_bit;
    end
  end

  // Each one of the NRZI stream goes to the two sides in turn.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= 1'b0;
      pos_reg <= 1'b0;
      neg_reg <= 1'b0;
    end else begin
      pos_reg <= nrzi_reg && !phase_reg;
      neg_reg <= nrzi_reg && phase_reg;
      if (nrzi_reg) begin
        phase_reg <= !phase_reg;
      end
    end
  end

  assign nrzi_out = nrzi_reg;
  assign mlt_pos = pos_reg;
  assign mlt_neg = neg_reg;

  nrzi_follow_a: assert property (@(posedge pclk) disable iff (!presetn)
    nrzi_reg != $past(nrzi_reg) |-> $past(scr_bit))
    else $error("NRZI changed without a one");

  mlt_split_a: assert property (@(posedge pclk) disable iff (!presetn)
    nrzi_reg |=> (pos_reg != neg_reg))
    else $error("MLT-3 one event not on exactly one stream");

  lfsr_live_a: assert property (@(posedge pclk) disable iff (!presetn)
    lfsr_reg != 11'h000)
    else $error("scrambler locked at zero");

endmodule : line_coder
`default_nettype wire

// ---- hw/phy_tx_encoder_link_status.sv ----
// Top of the 100 Mb/s transmit path with link indicators, duplex handling, loopback and APB registers.
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module phy_tx_encoder_link_status #(
  parameter int FAST_LINK_COUNT = phy_tx_pkg::FAST_LINK_CYCLES,
  parameter int LINK_LOSS_COUNT = phy_tx_pkg::LINK_LOSS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_en,
  input wire logic [3:0] txd,
  input wire logic [4:0] raw_sym,
  output logic nibble_take,
  input wire logic rx_active,
  input wire logic signal_detect,
  input wire logic link_pulse,
  input wire logic good_slow_packet,
  input wire logic parallel_detect,
  output logic carrier_sense,
  output logic collision,
  output logic mac_loopback,
  output logic loop_bit,
  output logic activity_led_n,
  output logic fast_link_led_n,
  output logic slow_link_led_n,
  output logic tx_line_pair_pos,
  output logic tx_line_pair_neg
);
  import phy_tx_pkg::*;

  // ==========================================================================
  // APB register file
  logic [31:0] bmc_reg, tx_config_reg, rx_config_reg, cfg_reg, rdata_reg;
  logic [31:0] status_word;
  logic mapped, wr_take;
  logic loop_on, full_duplex;

  function automatic logic is_mapped(input logic [11:0] a);
    return (a == BMC_ADDR) || (a == TX_CONFIG_ADDR) || (a == RX_CONFIG_ADDR)
      || (a == CFG_ADDR) || (a == PHY_STATUS_ADDR);
  endfunction : is_mapped

  assign mapped = is_mapped(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_take = psel && penable && pwrite && mapped;
  assign prdata = rdata_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bmc_reg <= BMC_RESET;
      tx_config_reg <= REG_RESET;
      rx_config_reg <= REG_RESET;
      cfg_reg <= REG_RESET;
    end else if (wr_take) begin
      unique case (paddr)
        BMC_ADDR: bmc_reg <= pwdata;
        TX_CONFIG_ADDR: tx_config_reg <= pwdata;
        RX_CONFIG_ADDR: rx_config_reg <= pwdata;
        CFG_ADDR: cfg_reg <= pwdata;
        default: ;
      endcase
    end
  end

  // Read data is captured in the setup cycle so the access phase needs no wait state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        BMC_ADDR: rdata_reg <= bmc_reg;
        TX_CONFIG_ADDR: rdata_reg <= tx_config_reg;
        RX_CONFIG_ADDR: rdata_reg <= rx_config_reg;
        CFG_ADDR: rdata_reg <= cfg_reg;
        PHY_STATUS_ADDR: rdata_reg <= status_word;
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Duplex, carrier and collision
  logic fast_speed;
  // A fixed-speed partner found by parallel detection cannot show full duplex.
  assign full_duplex = bmc_reg[BMC_DUPLEX_BIT] && !parallel_detect;
  assign fast_speed = bmc_reg[BMC_SPEED_BIT];
  assign loop_on = bmc_reg[BMC_LOOP_BIT];
  assign mac_loopback = tx_config_reg[TX_CONFIG_MACLOOP_BIT];

  logic enc_tx_active;
  always_comb begin
    carrier_sense = rx_active || (!full_duplex && (enc_tx_active || tx_en));
    collision = !full_duplex && rx_active && (enc_tx_active || tx_en) && !loop_on;
  end

  assign activity_led_n = !(rx_active || tx_en || enc_tx_active);

  // ==========================================================================
  // Fast link indicator
  logic [31:0] sd_cnt_reg;
  logic fast_link_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sd_cnt_reg <= 32'h0;
      fast_link_reg <= 1'b0;
    end else if (!signal_detect) begin
      sd_cnt_reg <= 32'h0;
      fast_link_reg <= 1'b0;
    end else if (sd_cnt_reg == 32'(FAST_LINK_COUNT - 1)) begin
      fast_link_reg <= 1'b1;
    end else begin
      sd_cnt_reg <= sd_cnt_reg + 32'h1;
    end
  end

  // Release is combinational on detect so no cycle of stale link is shown.
  assign fast_link_led_n = !(fast_link_reg && signal_detect);

  // ==========================================================================
  // Slow link indicator
  logic [2:0] nlp_cnt_reg;
  logic [31:0] loss_cnt_reg;
  logic slow_link_reg;
  logic link_seen;

  assign link_seen = link_pulse || good_slow_packet;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nlp_cnt_reg <= 3'h0;
      loss_cnt_reg <= 32'h0;
      slow_link_reg <= 1'b0;
    end else if (link_seen) begin
      loss_cnt_reg <= 32'h0;
      if (good_slow_packet || nlp_cnt_reg == NLP_NEEDED - 3'h1) begin
        slow_link_reg <= 1'b1;
      end
      if (nlp_cnt_reg != NLP_NEEDED) begin
        nlp_cnt_reg <= nlp_cnt_reg + 3'h1;
      end
    end else if (loss_cnt_reg == 32'(LINK_LOSS_COUNT - 1)) begin
      slow_link_reg <= 1'b0;
      nlp_cnt_reg <= 3'h0;
    end else begin
      loss_cnt_reg <= loss_cnt_reg + 32'h1;
    end
  end

  assign slow_link_led_n = !slow_link_reg;

  assign status_word = (32'(loop_on) << STS_LOOP_BIT) | (32'(full_duplex) << STS_DUPLEX_BIT)
    | (32'(!fast_speed) << STS_SPEED10_BIT) | (32'(fast_link_reg || slow_link_reg) << STS_LINK_BIT);

  // ==========================================================================
  // Transmit path
  tx_bit_if bits_if ();
  logic mlt_pos, mlt_neg;

  cg_encoder u_enc (
    .pclk(pclk),
    .presetn(presetn),
    .tx_en(tx_en),
    .txd(txd),
    .raw_sym(raw_sym),
    .enc_bypass(cfg_reg[CFG_ENC_BYP_BIT]),
    .nibble_take(nibble_take),
    .bits(bits_if.src)
  );

  line_coder u_line (
    .pclk(pclk),
    .presetn(presetn),
    .scr_bypass(cfg_reg[CFG_SCR_BYP_BIT]),
    .nrzi_out(),
    .mlt_pos(mlt_pos),
    .mlt_neg(mlt_neg),
    .bits(bits_if.dst)
  );

  assign enc_tx_active = bits_if.tx_active;

  // Loopback turns the MLT-3 pair around after the last line stage.
  logic pos_reg, neg_reg, loop_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_reg <= 1'b0;
      neg_reg <= 1'b0;
      loop_reg <= 1'b0;
    end else begin
      pos_reg <= mlt_pos && !loop_on;
      neg_reg <= mlt_neg && !loop_on;
      loop_reg <= loop_on && (mlt_pos || mlt_neg);
    end
  end

  assign tx_line_pair_pos = pos_reg;
  assign tx_line_pair_neg = neg_reg;
  assign loop_bit = loop_reg;

  // ==========================================================================
  // Checks
  activity_led_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rx_active || tx_en) |-> !activity_led_n)
    else $error("activity LED not lit");

  fast_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(fast_link_led_n) |-> $past(sd_cnt_reg) == 32'(FAST_LINK_COUNT - 1) && $past(signal_detect))
    else $error("fast link LED lit too early");

  fast_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
    !signal_detect |-> fast_link_led_n)
    else $error("fast link LED not released");

  slow_up_a: assert property (@(posedge pclk) disable iff (!presetn)
    (link_pulse && nlp_cnt_reg == 3'h6) || good_slow_packet |=> !slow_link_led_n)
    else $error("slow link not declared");

  slow_loss_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!link_seen && loss_cnt_reg == 32'(LINK_LOSS_COUNT - 1)) |=> slow_link_led_n)
    else $error("slow link not released on loss");

  full_nocol_a: assert property (@(posedge pclk) disable iff (!presetn)
    full_duplex |-> !collision)
    else $error("collision in full duplex");

  half_carrier_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!full_duplex && tx_en) |-> carrier_sense)
    else $error("no carrier for own transmit");

  pd_half_a: assert property (@(posedge pclk) disable iff (!presetn)
    parallel_detect |-> !status_word[STS_DUPLEX_BIT])
    else $error("parallel detect left full duplex");

  loop_quiet_a: assert property (@(posedge pclk) disable iff (!presetn)
    loop_on |=> !tx_line_pair_pos && !tx_line_pair_neg)
    else $error("line driven in loopback");

  loop_status_a: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && !pwrite && paddr == PHY_STATUS_ADDR |=> prdata[STS_LOOP_BIT] == $past(loop_on))
    else $error("loopback status wrong");

  rx_carrier_a: assert property (@(posedge pclk) disable iff (!presetn)
    (!full_duplex && rx_active) |-> carrier_sense)
    else $error("no carrier for receive");

  loop_enable_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_take && paddr == BMC_ADDR && pwdata[BMC_LOOP_BIT] |=> loop_on)
    else $error("loopback not enabled by control write");

  loop_turn_a: assert property (@(posedge pclk) disable iff (!presetn)
    (loop_on && (mlt_pos || mlt_neg)) |=> loop_bit)
    else $error("line stage output not turned around");

  mac_loop_a: assert property (@(posedge pclk) disable iff (!presetn)
    wr_take && paddr == TX_CONFIG_ADDR && pwdata[TX_CONFIG_MACLOOP_BIT] |=> mac_loopback)
    else $error("MAC loopback not enabled");

endmodule : phy_tx_encoder_link_status
`default_nettype wire

// ---- bench/link_partner.sv ----
// Far-end link partner model that recovers the NRZ bit history from the two MLT-3 streams.
`timescale 1ns/1ns
`default_nettype none
module link_partner (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic line_pos,
  input wire logic line_neg,
  output logic [199:0] hist,
  output logic [7:0] clash_cnt
);
  logic nrzi_prev;
  // ==========================================================================
  // Line receiver
  // A one on either stream is a high NRZI level, and a change of level is a one in the NRZ stream.
  // Newest bit sits at index 0, so older symbols are found at higher indices.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nrzi_prev <= 1'b0;
      hist <= '0;
    end else begin
      nrzi_prev <= line_pos | line_neg;
      hist <= {hist[198:0], (line_pos | line_neg) ^ nrzi_prev};
    end
  end
  // Both sides of the transformer driven at once would short the winding.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clash_cnt <= '0;
    end else if (line_pos && line_neg) begin
      clash_cnt <= clash_cnt + 8'h01;
    end
  end
endmodule : link_partner
`default_nettype wire

// ---- bench/tb.sv ----
// Self-checking bench for the transmit path, link indicators, duplex handling and loopback.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin error_cnt++; $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb;
  import phy_tx_pkg::*;
  // ==========================================================================
  // Signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic tx_en = 1'b0;
  logic [3:0] txd = '0;
  logic [4:0] raw_sym = '0;
  logic rx_active = 1'b0;
  logic signal_detect = 1'b0;
  logic link_pulse = 1'b0;
  logic good_slow_packet = 1'b0;
  logic parallel_detect = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, nibble_take, carrier_sense, collision, mac_loopback, loop_bit;
  logic activity_led_n, fast_link_led_n, slow_link_led_n, tx_line_pair_pos, tx_line_pair_neg;
  logic [199:0] hist;
  logic [7:0] clash_cnt;
  int error_cnt = 0;
  int cmp_count = 0;
  localparam logic [4:0] DG [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                                     5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};

  always #5 pclk = ~pclk;

  phy_tx_encoder_link_status #(.FAST_LINK_COUNT(20), .LINK_LOSS_COUNT(50)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .tx_en, .txd, .raw_sym, .nibble_take, .rx_active, .signal_detect, .link_pulse, .good_slow_packet,
    .parallel_detect, .carrier_sense, .collision, .mac_loopback, .loop_bit, .activity_led_n,
    .fast_link_led_n, .slow_link_led_n, .tx_line_pair_pos, .tx_line_pair_neg);

  link_partner lp (.pclk(pclk), .presetn(presetn), .line_pos(tx_line_pair_pos),
    .line_neg(tx_line_pair_neg), .hist(hist), .clash_cnt(clash_cnt));

  // ==========================================================================
  // Bus and helper tasks
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      error_cnt++;
      report_and_stop();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask : rd

  task automatic pulse(input logic pkt);
    @(posedge pclk);
    link_pulse <= !pkt;
    good_slow_packet <= pkt;
    @(posedge pclk);
    link_pulse <= 1'b0;
    good_slow_packet <= 1'b0;
  endtask : pulse

  // ==========================================================================
  // Scenarios
  task automatic t_regs;
    logic [31:0] q;
    logic e;
    rd(BMC_ADDR, q);
    `CHK("control reset", 32'h0000_2000, q)
    wr(PHY_STATUS_ADDR, 32'hffff_ffff);
    rd(PHY_STATUS_ADDR, q);
    `CHK("status loop bit", 1'b0, q[STS_LOOP_BIT])
    apb(1'b0, 12'h100, 32'h0, q, e);
    `CHK("unmapped error", 1'b1, e)
    `CHK("unmapped data", 32'h0, q)
  endtask : t_regs

  task automatic t_links;
    @(posedge pclk);
    signal_detect <= 1'b1;
    repeat (12) @(posedge pclk);
    `CHK("fast link early", 1'b1, fast_link_led_n)
    repeat (14) @(posedge pclk);
    `CHK("fast link up", 1'b0, fast_link_led_n)
    signal_detect <= 1'b0;
    #1;
    `CHK("fast link drop", 1'b1, fast_link_led_n)
    repeat (6) pulse(1'b0);
    repeat (2) @(posedge pclk);
    `CHK("slow link six", 1'b1, slow_link_led_n)
    pulse(1'b0);
    repeat (40) @(posedge pclk);
    `CHK("slow link seven", 1'b0, slow_link_led_n)
    repeat (20) @(posedge pclk);
    `CHK("slow link loss", 1'b1, slow_link_led_n)
    pulse(1'b1);
    repeat (2) @(posedge pclk);
    `CHK("slow link packet", 1'b0, slow_link_led_n)
    repeat (60) @(posedge pclk);
    `CHK("slow link loss 2", 1'b1, slow_link_led_n)
  endtask : t_links

  task automatic t_duplex;
    logic [31:0] q;
    @(posedge pclk);
    rx_active <= 1'b1;
    #1;
    `CHK("activity rx", 1'b0, activity_led_n)
    `CHK("carrier rx", 1'b1, carrier_sense)
    @(posedge pclk);
    rx_active <= 1'b0;
    tx_en <= 1'b1;
    #1;
    `CHK("activity tx", 1'b0, activity_led_n)
    `CHK("carrier tx", 1'b1, carrier_sense)
    @(posedge pclk);
    rx_active <= 1'b1;
    #1;
    `CHK("half collision", 1'b1, collision)
    wr(TX_CONFIG_ADDR, 32'hc000_0000);
    wr(RX_CONFIG_ADDR, 32'h1000_0000);
    wr(CFG_ADDR, 32'h0000_6000);
    wr(BMC_ADDR, 32'h0000_2100);
    rd(PHY_STATUS_ADDR, q);
    `CHK("full duplex status", 1'b1, q[STS_DUPLEX_BIT])
    `CHK("full collision", 1'b0, collision)
    @(posedge pclk);
    parallel_detect <= 1'b1;
    rd(PHY_STATUS_ADDR, q);
    `CHK("parallel duplex", 1'b0, q[STS_DUPLEX_BIT])
    `CHK("parallel collision", 1'b1, collision)
    parallel_detect <= 1'b0;
    tx_en <= 1'b0;
    rx_active <= 1'b0;
    wr(BMC_ADDR, 32'h0000_2000);
    repeat (40) @(posedge pclk);
  endtask : t_duplex

  task automatic t_frame;
    logic [109:0] ex;
    int i;
    int n;
    logic hit;
    ex = {100'h0, CG_J, CG_K};
    for (int k = 0; k < 16; k++) ex = {ex[104:0], DG[k]};
    ex = {ex[99:0], 5'h0d, 5'h07};
    ex = {ex[99:0], 5'h1f, 5'h1f};
    wr(CFG_ADDR, 32'h0000_0002);
    @(posedge pclk);
    txd <= 4'h5;
    tx_en <= 1'b1;
    i = 0;
    n = 0;
    while (i < 18 && n < 200) begin
      @(posedge pclk);
      n++;
      if (nibble_take === 1'b1) begin
        i++;
        txd <= (i < 2) ? 4'h5 : 4'(i - 2);
        if (i == 18) tx_en <= 1'b0;
      end
    end
    if (n >= 200) begin
      error_cnt++;
      report_and_stop();
    end
    repeat (40) @(posedge pclk);
    hit = 1'b0;
    for (int o = 0; o <= 90; o++) if (hist[o+:110] === ex) hit = 1'b1;
    `CHK("frame bits", 1'b1, hit)
  endtask : t_frame

  task automatic t_bypass;
    logic hit;
    logic ok;
    wr(CFG_ADDR, 32'h0000_0003);
    raw_sym <= 5'h04;
    repeat (40) @(posedge pclk);
    hit = 1'b0;
    for (int o = 0; o < 5; o++) if (hist[o+:20] === {4{5'h04}}) hit = 1'b1;
    `CHK("bypass symbols", 1'b1, hit)
    wr(CFG_ADDR, 32'h0000_0000);
    repeat (70) @(posedge pclk);
    ok = 1'b1;
    for (int j = 0; j < 40; j++) if (hist[j] !== ~(hist[j+9] ^ hist[j+11])) ok = 1'b0;
    `CHK("scrambler recurrence", 1'b1, ok)
    `CHK("scrambler active", 1'b1, hist[39:0] !== '1)
  endtask : t_bypass

  task automatic t_loop;
    logic [31:0] q;
    int ones;
    int line;
    ones = 0;
    line = 0;
    wr(BMC_ADDR, 32'h0000_6000);
    rd(PHY_STATUS_ADDR, q);
    `CHK("loop status", 1'b1, q[STS_LOOP_BIT])
    repeat (40) begin
      @(posedge pclk);
      if (loop_bit === 1'b1) ones++;
      if (tx_line_pair_pos !== 1'b0 || tx_line_pair_neg !== 1'b0) line++;
    end
    `CHK("loop line quiet", 0, line)
    `CHK("loop path live", 1'b1, ones > 0)
    wr(TX_CONFIG_ADDR, 32'h2000_0000);
    @(posedge pclk);
    `CHK("mac loopback on", 1'b1, mac_loopback)
    wr(TX_CONFIG_ADDR, 32'h0000_0000);
    @(posedge pclk);
    `CHK("mac loopback off", 1'b0, mac_loopback)
    wr(BMC_ADDR, 32'h0000_2000);
    rd(PHY_STATUS_ADDR, q);
    `CHK("loop status off", 1'b0, q[STS_LOOP_BIT])
  endtask : t_loop

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge pclk);
    `CHK("reset fast led", 1'b1, fast_link_led_n)
    `CHK("reset slow led", 1'b1, slow_link_led_n)
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_links();
    t_duplex();
    t_frame();
    t_bypass();
    t_loop();
    `CHK("stream clash", 8'h00, clash_cnt)
    report_and_stop();
  end

  initial begin
    repeat (100000) @(posedge pclk);
    error_cnt++;
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
